/* File: core/qt_range_pkg.sv */
// Shared constants and types for the quick-trip ranging register bank
// What this block does
// RULE_01: The receive-power ranging register picks the full scale of the fast signal-loss checks.
// RULE_02: Bits 6:4 hold the high signal-loss range, eight steps from 100 to 25 percent of 1.25 V.
// RULE_03: Bits 2:0 hold the low signal-loss range with the same steps, code 111b giving 0.313 V.
// RULE_04: Bits 7 and 3 of both ranging registers are reserved and hold zero.
// RULE_05: The upper nibble of the comparator ranging register sets the bias-current check range.
// RULE_06: The bias-current range defaults to 000b for 1.25 V and scales down in the same steps.
// RULE_07: The lower nibble sets the range of the power-control reference check and loop monitor.
// RULE_08: The power-control range scales 2.50 V the same way, 000b 2.500 V and 110b 0.714 V.
// RULE_09: The signal-loss ranging register reads under the higher level, or the lower level with either table permit.
// RULE_10: The signal-loss ranging register takes writes under the higher level, or the lower level with read-write permit.
// RULE_11: A level is granted while the entered value matches its stored password; entry resets to all ones.
// RULE_12: The comparator ranging register is reached only under the higher level; other accesses are refused.
// RULE_13: Both ranging registers live in nonvolatile storage and keep their values across reset; the power-on strobe por_n reloads them with zero.
package qt_range_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] LOSS_RANGE_IDX = 8'hb8;
  localparam logic [7:0] COMP_RANGE_IDX = 8'hb9;
  localparam logic [7:0] PW_ENTRY_IDX   = 8'hc8;
  localparam logic [7:0] LOWER_PW_IDX   = 8'hc9;
  localparam logic [7:0] HIGHER_PW_IDX  = 8'hca;
  localparam logic [7:0] PERMIT_IDX     = 8'hcb;
  localparam logic [7:0] LEVEL_IDX      = 8'hcc;

  // Field layout of both ranging registers
  localparam int unsigned FIELD_W   = 3;
  localparam int unsigned HI_LSB    = 4;
  localparam int unsigned LO_LSB    = 0;
  localparam logic [7:0]  RSVD_MASK = 8'h77;

  // Permit and level bits
  localparam int unsigned PERMIT_RW_BIT = 0;
  localparam int unsigned PERMIT_RO_BIT = 1;
  localparam int unsigned LEVEL_LO_BIT  = 0;
  localparam int unsigned LEVEL_HI_BIT  = 1;

  // Reset and factory values
  localparam logic [7:0]  RANGE_RST  = 8'h00;
  localparam logic [31:0] PW_RST     = 32'hffff_ffff;
  localparam logic [31:0] ENTRY_RST  = 32'hffff_ffff;
  localparam logic [1:0]  PERMIT_RST = 2'h0;

  // Full scales in millivolts
  localparam int unsigned LOSS_FS_MV  = 1250;
  localparam int unsigned BIAS_FS_MV  = 1250;
  localparam int unsigned POWER_FS_MV = 2500;
  localparam int unsigned FS_W        = 12;

  // Ratio of full scale per code, in units of 0.01 percent
  localparam logic [7:0][13:0] RATIO_BP = {
    14'd2500, 14'd2857, 14'd3333, 14'd4000,
    14'd5000, 14'd6667, 14'd8000, 14'd10000};
  localparam int unsigned RATIO_ONE = 10000;

  // Nonvolatile slots
  localparam int unsigned NV_SLOTS  = 4;
  localparam logic [1:0] SLOT_LOSS  = 2'h0;
  localparam logic [1:0] SLOT_COMP  = 2'h1;
  localparam logic [1:0] SLOT_LOWPW = 2'h2;
  localparam logic [1:0] SLOT_HIPW  = 2'h3;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [FIELD_W-1:0] high_sig_loss_range;
    logic [FIELD_W-1:0] low_sig_loss_range;
    logic [FIELD_W-1:0] bias_current_range;
    logic [FIELD_W-1:0] power_ctrl_range;
  } range_cfg_t;

  typedef struct packed {
    logic [FS_W-1:0] high_sig_loss_mv;
    logic [FS_W-1:0] low_sig_loss_mv;
    logic [FS_W-1:0] bias_current_mv;
    logic [FS_W-1:0] power_ctrl_mv;
  } range_fs_t;

endpackage : qt_range_pkg

/* File: core/range_scaler.sv */
// Converts a 3-bit range code to a full scale in millivolts
`timescale 1ns/1ps
module range_scaler #(
  parameter int unsigned FULL_MV = 1250
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Code in, scale out
  input  wire logic [qt_range_pkg::FIELD_W-1:0] code,
  output logic      [qt_range_pkg::FS_W-1:0]    fs_mv
);
  typedef struct packed {
    logic [qt_range_pkg::FS_W-1:0] fs;
  } scaler_state_t;

  scaler_state_t st_r;
  scaler_state_t st_nxt;
  logic [31:0]   prod;

  // Rounded to nearest, so 312.5 mV shows as 313
  always_comb begin
    prod = 32'(FULL_MV) * 32'(qt_range_pkg::RATIO_BP[code]);
    st_nxt.fs = qt_range_pkg::FS_W'((prod + 32'(qt_range_pkg::RATIO_ONE / 2))
                / 32'(qt_range_pkg::RATIO_ONE));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fs_mv = st_r.fs;
endmodule : range_scaler

/* File: core/nv_word_store.sv */
// Nonvolatile word store, loaded with factory values only by its own power-on strobe
`timescale 1ns/1ps
module nv_word_store #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned W     = 32
) (
  // Clock and power-on
  input  wire logic                       aclk,
  input  wire logic                       por_n,
  input  wire logic [DEPTH-1:0][W-1:0]    factory,
  // Write port
  input  wire logic                       we,
  input  wire logic [$clog2(DEPTH)-1:0]   wslot,
  input  wire logic [W-1:0]               wdata,
  // Contents
  output logic      [DEPTH-1:0][W-1:0]    words
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
  } store_state_t;

  store_state_t st_r;
  store_state_t st_nxt;

  // Bus reset does not reach here, so values outlive it
  always_comb begin
    st_nxt = st_r;
    if (we) begin
      st_nxt.mem[wslot] = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!por_n) begin
      st_r.mem <= factory;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign words = st_r.mem;
endmodule : nv_word_store

/* File: core/qt_range_regs.sv */
// AXI4-Lite bank of quick-trip ranging registers with password gating
`timescale 1ns/1ps
module qt_range_regs #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and resets
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 por_n,
  // Write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  // Write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // Write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic      [1:0]           s_axi_bresp,
  // Read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  // Read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  // Ranges toward the comparators
  output qt_range_pkg::range_cfg_t  range_cfg,
  output qt_range_pkg::range_fs_t   range_fs,
  // Access levels in force
  output logic                      lower_password_level,
  output logic                      higher_password_level
);
  localparam int unsigned IDX_W = ADDR_W - 2;

  typedef struct packed {
    logic              aw_ok;
    logic [IDX_W-1:0]  aw_idx;
    logic              w_ok;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              b_ok;
    logic [1:0]        b_resp;
    logic              r_ok;
    logic [31:0]       r_data;
    logic [1:0]        r_resp;
    logic [31:0]       entered_password_value;
    logic              table_readwrite_permit;
    logic              table_readonly_permit;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  // Nonvolatile contents
  logic [qt_range_pkg::NV_SLOTS-1:0][31:0] nv_words;
  logic [qt_range_pkg::NV_SLOTS-1:0][31:0] nv_factory;
  logic                                    nv_we;
  logic [1:0]                              nv_slot;
  logic [31:0]                             nv_wdata;

  // Decode helpers
  logic [7:0]   loss_byte;
  logic [7:0]   comp_byte;
  logic         lvl_lo;
  logic         lvl_hi;
  logic         loss_rd_ok;
  logic         loss_wr_ok;
  logic [31:0]  merged;
  logic [31:0]  rd_word;
  logic [1:0]   rd_resp;
  logic [IDX_W-1:0] ar_idx;

  // Byte-lane merge of the held write into an old word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Index match against a register number
  function automatic logic idx_is(
    input logic [IDX_W-1:0] idx,
    input logic [7:0]       reg_num
  );
    return idx == IDX_W'(reg_num);
  endfunction : idx_is

  assign nv_factory[qt_range_pkg::SLOT_LOSS] =
    32'(qt_range_pkg::RANGE_RST);
  assign nv_factory[qt_range_pkg::SLOT_COMP] =
    32'(qt_range_pkg::RANGE_RST);
  assign nv_factory[qt_range_pkg::SLOT_LOWPW] = qt_range_pkg::PW_RST;
  assign nv_factory[qt_range_pkg::SLOT_HIPW]  = qt_range_pkg::PW_RST;

  // Ranging bytes and passwords survive bus reset
  nv_word_store #(
    .DEPTH (qt_range_pkg::NV_SLOTS),
    .W     (32)
  ) u_nv (
    .aclk    (aclk),
    .por_n   (por_n),
    .factory (nv_factory),
    .we      (nv_we),
    .wslot   (nv_slot),
    .wdata   (nv_wdata),
    .words   (nv_words)
  ); // [RULE_13]

  assign loss_byte = nv_words[qt_range_pkg::SLOT_LOSS][7:0];
  assign comp_byte = nv_words[qt_range_pkg::SLOT_COMP][7:0];

  // Levels follow the entered value live; no latch of a past match
  assign lvl_lo = st_r.entered_password_value ==
                  nv_words[qt_range_pkg::SLOT_LOWPW]; // [RULE_11]
  assign lvl_hi = st_r.entered_password_value ==
                  nv_words[qt_range_pkg::SLOT_HIPW]; // [RULE_11]

  assign loss_rd_ok = lvl_hi |
    (lvl_lo & (st_r.table_readwrite_permit |
               st_r.table_readonly_permit)); // [RULE_09]
  assign loss_wr_ok = lvl_hi |
    (lvl_lo & st_r.table_readwrite_permit); // [RULE_10]

  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_resp = qt_range_pkg::RESP_OKAY;
    if (idx_is(ar_idx, qt_range_pkg::LOSS_RANGE_IDX)) begin
      if (loss_rd_ok) begin
        rd_word = 32'(loss_byte); // [RULE_01]
      end else begin
        rd_resp = qt_range_pkg::RESP_SLVERR; // [RULE_09]
      end
    end else if (idx_is(ar_idx, qt_range_pkg::COMP_RANGE_IDX)) begin
      if (lvl_hi) begin
        rd_word = 32'(comp_byte);
      end else begin
        rd_resp = qt_range_pkg::RESP_SLVERR; // [RULE_12]
      end
    end else if (idx_is(ar_idx, qt_range_pkg::PW_ENTRY_IDX) ||
                 idx_is(ar_idx, qt_range_pkg::LOWER_PW_IDX) ||
                 idx_is(ar_idx, qt_range_pkg::HIGHER_PW_IDX)) begin
      // Passwords never leave the chip; they read as zero
      rd_word = '0;
    end else if (idx_is(ar_idx, qt_range_pkg::PERMIT_IDX)) begin
      rd_word[qt_range_pkg::PERMIT_RW_BIT] = st_r.table_readwrite_permit;
      rd_word[qt_range_pkg::PERMIT_RO_BIT] = st_r.table_readonly_permit;
    end else if (idx_is(ar_idx, qt_range_pkg::LEVEL_IDX)) begin
      rd_word[qt_range_pkg::LEVEL_LO_BIT] = lvl_lo;
      rd_word[qt_range_pkg::LEVEL_HI_BIT] = lvl_hi;
    end else begin
      rd_resp = qt_range_pkg::RESP_DECERR;
    end
  end

  // Main next-state logic
  always_comb begin
    st_nxt   = st_r;
    nv_we    = 1'b0;
    nv_slot  = qt_range_pkg::SLOT_LOSS;
    nv_wdata = '0;
    merged   = '0;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && !st_r.aw_ok) begin
      st_nxt.aw_ok  = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && !st_r.w_ok) begin
      st_nxt.w_ok   = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end

    if (st_r.b_ok && s_axi_bready) begin
      st_nxt.b_ok = 1'b0;
    end

    // Perform the write once both halves are held
    if (st_r.aw_ok && st_r.w_ok && !st_r.b_ok) begin
      st_nxt.aw_ok  = 1'b0;
      st_nxt.w_ok   = 1'b0;
      st_nxt.b_ok   = 1'b1;
      st_nxt.b_resp = qt_range_pkg::RESP_OKAY;
      if (idx_is(st_r.aw_idx, qt_range_pkg::LOSS_RANGE_IDX)) begin
        if (loss_wr_ok) begin
          nv_slot  = qt_range_pkg::SLOT_LOSS;
          merged   = lane_merge(32'(loss_byte), st_r.w_data, st_r.w_strb);
          nv_wdata = 32'(merged[7:0] & qt_range_pkg::RSVD_MASK); // [RULE_04]
          nv_we    = 1'b1; // [RULE_02] [RULE_03]
        end else begin
          st_nxt.b_resp = qt_range_pkg::RESP_SLVERR; // [RULE_10]
        end
      end else if (idx_is(st_r.aw_idx, qt_range_pkg::COMP_RANGE_IDX)) begin
        if (lvl_hi) begin
          nv_slot  = qt_range_pkg::SLOT_COMP;
          merged   = lane_merge(32'(comp_byte), st_r.w_data, st_r.w_strb);
          nv_wdata = 32'(merged[7:0] & qt_range_pkg::RSVD_MASK); // [RULE_04]
          nv_we    = 1'b1; // [RULE_05] [RULE_07]
        end else begin
          st_nxt.b_resp = qt_range_pkg::RESP_SLVERR; // [RULE_12]
        end
      end else if (idx_is(st_r.aw_idx, qt_range_pkg::PW_ENTRY_IDX)) begin
        st_nxt.entered_password_value = lane_merge(
          st_r.entered_password_value, st_r.w_data, st_r.w_strb);
      end else if (idx_is(st_r.aw_idx, qt_range_pkg::LOWER_PW_IDX)) begin
        if (lvl_hi || lvl_lo) begin
          nv_slot  = qt_range_pkg::SLOT_LOWPW;
          nv_wdata = lane_merge(nv_words[qt_range_pkg::SLOT_LOWPW],
                                st_r.w_data, st_r.w_strb);
          nv_we    = 1'b1;
        end else begin
          st_nxt.b_resp = qt_range_pkg::RESP_SLVERR;
        end
      end else if (idx_is(st_r.aw_idx, qt_range_pkg::HIGHER_PW_IDX)) begin
        if (lvl_hi) begin
          nv_slot  = qt_range_pkg::SLOT_HIPW;
          nv_wdata = lane_merge(nv_words[qt_range_pkg::SLOT_HIPW],
                                st_r.w_data, st_r.w_strb);
          nv_we    = 1'b1;
        end else begin
          st_nxt.b_resp = qt_range_pkg::RESP_SLVERR;
        end
      end else if (idx_is(st_r.aw_idx, qt_range_pkg::PERMIT_IDX)) begin
        // Only the higher level may hand out table permits
        if (lvl_hi) begin
          if (st_r.w_strb[0]) begin
            st_nxt.table_readwrite_permit =
              st_r.w_data[qt_range_pkg::PERMIT_RW_BIT];
            st_nxt.table_readonly_permit =
              st_r.w_data[qt_range_pkg::PERMIT_RO_BIT];
          end
        end else begin
          st_nxt.b_resp = qt_range_pkg::RESP_SLVERR;
        end
      end else if (idx_is(st_r.aw_idx, qt_range_pkg::LEVEL_IDX)) begin
        st_nxt.b_resp = qt_range_pkg::RESP_SLVERR;
      end else begin
        st_nxt.b_resp = qt_range_pkg::RESP_DECERR;
      end
    end

    // Read channel
    if (st_r.r_ok && s_axi_rready) begin
      st_nxt.r_ok = 1'b0;
    end
    if (s_axi_arvalid && !st_r.r_ok) begin
      st_nxt.r_ok   = 1'b1;
      st_nxt.r_data = rd_word;
      st_nxt.r_resp = rd_resp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r.aw_ok  <= 1'b0;
      st_r.aw_idx <= '0;
      st_r.w_ok   <= 1'b0;
      st_r.w_data <= '0;
      st_r.w_strb <= '0;
      st_r.b_ok   <= 1'b0;
      st_r.b_resp <= qt_range_pkg::RESP_OKAY;
      st_r.r_ok   <= 1'b0;
      st_r.r_data <= '0;
      st_r.r_resp <= qt_range_pkg::RESP_OKAY;
      st_r.entered_password_value <= qt_range_pkg::ENTRY_RST; // [RULE_11]
      st_r.table_readwrite_permit <=
        qt_range_pkg::PERMIT_RST[qt_range_pkg::PERMIT_RW_BIT];
      st_r.table_readonly_permit <=
        qt_range_pkg::PERMIT_RST[qt_range_pkg::PERMIT_RO_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus handshakes; a held half blocks its own channel only
  assign s_axi_awready = !st_r.aw_ok;
  assign s_axi_wready  = !st_r.w_ok;
  assign s_axi_bvalid  = st_r.b_ok;
  assign s_axi_bresp   = st_r.b_resp;
  assign s_axi_arready = !st_r.r_ok;
  assign s_axi_rvalid  = st_r.r_ok;
  assign s_axi_rdata   = st_r.r_data;
  assign s_axi_rresp   = st_r.r_resp;

  assign lower_password_level  = lvl_lo;
  assign higher_password_level = lvl_hi;

  // Range codes straight from stored flops
  assign range_cfg.high_sig_loss_range =
    loss_byte[qt_range_pkg::HI_LSB +: qt_range_pkg::FIELD_W]; // [RULE_02]
  assign range_cfg.low_sig_loss_range =
    loss_byte[qt_range_pkg::LO_LSB +: qt_range_pkg::FIELD_W]; // [RULE_03]
  assign range_cfg.bias_current_range =
    comp_byte[qt_range_pkg::HI_LSB +: qt_range_pkg::FIELD_W]; // [RULE_05]
  assign range_cfg.power_ctrl_range =
    comp_byte[qt_range_pkg::LO_LSB +: qt_range_pkg::FIELD_W]; // [RULE_07]

  // Full scales, one cycle behind the codes
  range_scaler #(
    .FULL_MV (qt_range_pkg::LOSS_FS_MV)
  ) u_high_loss (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (range_cfg.high_sig_loss_range),
    .fs_mv   (range_fs.high_sig_loss_mv)
  ); // [RULE_02]

  range_scaler #(
    .FULL_MV (qt_range_pkg::LOSS_FS_MV)
  ) u_low_loss (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (range_cfg.low_sig_loss_range),
    .fs_mv   (range_fs.low_sig_loss_mv)
  ); // [RULE_03]

  range_scaler #(
    .FULL_MV (qt_range_pkg::BIAS_FS_MV)
  ) u_bias (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (range_cfg.bias_current_range),
    .fs_mv   (range_fs.bias_current_mv)
  ); // [RULE_06]

  range_scaler #(
    .FULL_MV (qt_range_pkg::POWER_FS_MV)
  ) u_power (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (range_cfg.power_ctrl_range),
    .fs_mv   (range_fs.power_ctrl_mv)
  ); // [RULE_08]

endmodule : qt_range_regs

/* File: verification/qt_range_regs_sva.sv */
// Bus timing and range checks for the ranging register bank
`timescale 1ns/1ps
module qt_range_regs_sva #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and resets
  input wire logic aclk, aresetn, por_n,
  // Handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  // Payloads
  input wire logic [ADDR_W-1:0]       s_axi_awaddr, s_axi_araddr,
  input wire logic [2:0]              s_axi_awprot, s_axi_arprot,
  input wire logic [31:0]             s_axi_wdata, s_axi_rdata,
  input wire logic [3:0]              s_axi_wstrb,
  input wire logic [1:0]              s_axi_bresp, s_axi_rresp,
  // Ranges and levels
  input wire qt_range_pkg::range_cfg_t range_cfg,
  input wire qt_range_pkg::range_fs_t  range_fs,
  input wire logic lower_password_level, higher_password_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic              ar_go;
  logic [ADDR_W-1:0] last_ar_r;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  // Address of the read now being answered
  always_ff @(posedge aclk) begin
    if (!aresetn) last_ar_r <= '0;
    else if (ar_go) last_ar_r <= s_axi_araddr;
  end
  // Halves held one edge, write done the next, so bvalid shows two on
  a_write_resp_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_read_resp_lat: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  a_rsvd_bits_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 &&
    (last_ar_r == 12'h2e0 || last_ar_r == 12'h2e4) |->
    s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[7] && !s_axi_rdata[3])
    else $error("reserved bit set");
  a_comp_needs_hi: assert property (ar_go && s_axi_araddr == 12'h2e4 &&
    !higher_password_level |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("comparator range read not refused");
  a_loss_needs_lvl: assert property (ar_go && s_axi_araddr == 12'h2e0 &&
    !higher_password_level && !lower_password_level |=> s_axi_rresp == 2'h2)
    else $error("signal loss range read not refused");
  // Scales still read zero one edge after release, so that edge is skipped
  a_power_fs_top: assert property (aresetn &&
    range_cfg.power_ctrl_range == 3'h0 |=>
    range_fs.power_ctrl_mv == 12'd2500) else $error("power scale wrong");
  a_power_fs_six: assert property (aresetn &&
    range_cfg.power_ctrl_range == 3'h6 |=>
    range_fs.power_ctrl_mv == 12'd714) else $error("power scale wrong");
  a_loss_fs_low: assert property (aresetn &&
    range_cfg.low_sig_loss_range == 3'h7 |=>
    range_fs.low_sig_loss_mv == 12'd313) else $error("low loss scale wrong");
  a_bias_fs_top: assert property (aresetn &&
    range_cfg.bias_current_range == 3'h0 |=>
    range_fs.bias_current_mv == 12'd1250) else $error("bias scale wrong");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_read_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule : qt_range_regs_sva
bind qt_range_regs qt_range_regs_sva #(.ADDR_W(ADDR_W)) i_sva (.*);

/* File: verification/quick_trip_range_config_tb_top.sv */
// Self-checking bench for the ranging register bank
`timescale 1ns/1ps
module quick_trip_range_config_tb_top;
  logic aclk, aresetn, por_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic lower_password_level, higher_password_level;
  logic [11:0]               s_axi_awaddr, s_axi_araddr;
  logic [2:0]                s_axi_awprot, s_axi_arprot;
  logic [31:0]               s_axi_wdata, s_axi_rdata, r;
  logic [3:0]                s_axi_wstrb;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic [2:0]                lb;
  logic [33:0]               exp_r;
  qt_range_pkg::range_cfg_t  range_cfg;
  qt_range_pkg::range_fs_t   range_fs;
  logic [1:0]                wq[$];
  logic [33:0]               rq[$];
  int                        n_errors, checked;
  // Expected full scales per code
  int unsigned lv[8] = '{1250, 1000, 833, 625, 500, 417, 357, 313};
  int unsigned pv[8] = '{2500, 2000, 1667, 1250, 1000, 833, 714, 625};
  qt_range_regs #(.ADDR_W(12)) i_dut (.*);
  always #50 aclk = ~aclk;
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic rst(input bit p, input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    if (p) por_n <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
  endtask : rst
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    bit ta, tw, tb, dn;
    wq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    dn = 0;
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        dn = 1;
      end
    end
    @(negedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    bit ta, tr, dn;
    rq.push_back({e, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    dn = 0;
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        dn = 1;
      end
    end
    @(negedge aclk);
  endtask : rd
  task automatic chk_rng(input logic [2:0] h, l, b, p);
    chk("cfg", 48'(range_cfg), 48'({h, l, b, p}));
    chk("fs", range_fs, {12'(lv[h]), 12'(lv[l]), 12'(lv[b]), 12'(pv[p])});
  endtask : chk_rng
  task automatic lvl(input logic lo, hi);
    chk("levels", {lower_password_level, higher_password_level}, {lo, hi});
  endtask : lvl
  // Answers compared against the oldest note when they are taken
  always @(posedge aclk) begin
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      chk("bresp", s_axi_bresp, wq.pop_front());
    end
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      exp_r = rq.pop_front();
      chk("rresp", s_axi_rresp, exp_r[33:32]);
      chk("rdata", s_axi_rdata, exp_r[31:0]);
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim();
  end
  initial begin
    {aclk, aresetn, por_n, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    n_errors = 0;
    checked = 0;
    r = $urandom(23784);
    rst(1'b1, 12);
    @(negedge aclk);
    lvl(1'b1, 1'b1);
    rd(12'h2e0, 32'h0, 2'h0);
    rd(12'h2e4, 32'h0, 2'h0);
    chk_rng(3'h0, 3'h0, 3'h0, 3'h0);
    // Every code in the high loss and power fields, reserved bits written as ones and upper bytes random
    for (int c = 0; c < 8; c++) begin
      r = $urandom;
      lb = r[6:4];
      wr(12'h2e0, {r[31:8], 1'b1, 3'(c), 1'b1, r[2:0]}, 2'h0);
      rd(12'h2e0, {24'h0, 1'b0, 3'(c), 1'b0, r[2:0]}, 2'h0);
      wr(12'h2e4, {r[31:8], 1'b1, lb, 1'b1, 3'(c)}, 2'h0);
      rd(12'h2e4, {24'h0, 1'b0, lb, 1'b0, 3'(c)}, 2'h0);
      chk_rng(3'(c), r[2:0], lb, 3'(c));
    end
    // Lower level with table read-write permit only
    wr(12'h32c, 32'h1, 2'h0);
    wr(12'h328, 32'h5a5a_0001, 2'h0);
    lvl(1'b1, 1'b0);
    rd(12'h2e4, 32'h0, 2'h2);
    wr(12'h2e4, 32'h0, 2'h2);
    wr(12'h2e0, 32'h25, 2'h0);
    rd(12'h2e0, 32'h25, 2'h0);
    chk_rng(3'h2, 3'h5, lb, 3'h7);
    wr(12'h32c, 32'h2, 2'h2);
    // Higher level entered, then lower with read-only permit
    wr(12'h320, 32'h5a5a_0001, 2'h0);
    lvl(1'b0, 1'b1);
    wr(12'h32c, 32'h2, 2'h0);
    // Permit and level status readable, higher password reads as zero
    rd(12'h32c, 32'h2, 2'h0);
    rd(12'h330, 32'h2, 2'h0);
    rd(12'h328, 32'h0, 2'h0);
    wr(12'h330, 32'h0, 2'h2);
    wr(12'h320, 32'hffff_ffff, 2'h0);
    lvl(1'b1, 1'b0);
    wr(12'h2e0, 32'h11, 2'h2);
    rd(12'h2e0, 32'h25, 2'h0);
    wr(12'h320, 32'h1234_5678, 2'h0);
    lvl(1'b0, 1'b0);
    rd(12'h2e0, 32'h0, 2'h2);
    rd(12'h100, 32'h0, 2'h3);
    wr(12'h100, 32'h0, 2'h3);
    // Bus reset keeps stored ranges and passwords, clears permits
    rst(1'b0, 2);
    @(negedge aclk);
    @(negedge aclk);
    lvl(1'b1, 1'b0);
    chk_rng(3'h2, 3'h5, lb, 3'h7);
    rd(12'h2e0, 32'h0, 2'h2);
    rst(1'b1, 2);
    @(negedge aclk);
    @(negedge aclk);
    lvl(1'b1, 1'b1);
    chk_rng(3'h0, 3'h0, 3'h0, 3'h0);
    repeat (3) @(posedge aclk);
    end_sim();
  end
endmodule : quick_trip_range_config_tb_top
